// File: src/pio_port_block.v
`timescale 1ns/100ps
`include "pio_defs.vh"
module pio_port_block #(
  parameter WW = `PIO_WIDE_W,
  parameter NW = `PIO_NARROW_W
) (
  input  wire            i_clk_sys,
  input  wire            i_rstn,
  input  wire            i_bus_wr,
  input  wire            i_bus_rd,
  input  wire            i_hit_io,
  input  wire            i_hit_omc,
  input  wire            i_hit_imc,
  input  wire [1:0]      i_port_sel,
  input  wire [2:0]      i_reg_sel,
  input  wire [7:0]      i_wdata,
  input  wire [WW-1:0]   i_omc_first,
  input  wire [WW-1:0]   i_omc_shared,
  input  wire [NW-1:0]   i_ecs,
  input  wire [WW-1:0]   i_oe_pt_b,
  input  wire [WW-1:0]   i_oe_pt_c,
  input  wire [NW-1:0]   i_oe_pt_d,
  input  wire [WW-1:0]   i_oe_def_b,
  input  wire [WW-1:0]   i_oe_def_c,
  input  wire [NW-1:0]   i_oe_def_d,
  input  wire [3:0]      i_imc_pt,
  input  wire            i_isp_en,
  input  wire [3:0]      i_isp_out,
  input  wire [3:0]      i_isp_oe,
  input  wire [WW-1:0]   i_pin_b,
  input  wire [WW-1:0]   i_pin_c,
  input  wire [NW-1:0]   i_pin_d,
  output reg  [WW-1:0]   o_pin_b,
  output reg  [WW-1:0]   o_pin_c,
  output reg  [NW-1:0]   o_pin_d,
  output reg  [WW-1:0]   o_pin_oe_b,
  output reg  [WW-1:0]   o_pin_oe_c,
  output reg  [NW-1:0]   o_pin_oe_d,
  output reg  [WW-1:0]   o_array_in_b,
  output reg  [WW-1:0]   o_array_in_c,
  output reg  [NW-1:0]   o_array_in_d,
  output reg  [3:0]      o_isp_in,
  output reg  [7:0]      o_rdata,
  output reg             o_rvalid
);
  reg  [WW-1:0]   dout_b_q, dout_c_q;
  reg  [NW-1:0]   dout_d_q;
  reg  [WW-1:0]   dir_b_q, dir_c_q;
  reg  [NW-1:0]   dir_d_q;
  reg  [2*WW-1:0] src_b_q, src_c_q;
  reg  [2*NW-1:0] src_d_q;
  reg  [2*WW-1:0] imode_b_q, imode_c_q;
  wire [WW-1:0]   imc_b, imc_c;
  reg  [7:0]      rd_mux;
  integer         n;

  // Packs a narrow-port value into a byte with upper bits zero.
  function [7:0] pad_narrow;
    input [NW-1:0] v;
    begin
      pad_narrow = {{(8-NW){1'b0}}, v};
    end
  endfunction

  // Selects one output source for a pin.
  function pick_out;
    input [1:0] src;
    input       dout;
    input       output_macrocell;
    input       ecs;
    begin
      if (src == `PIO_SRC_OMC) begin
        pick_out = output_macrocell;
      end else if (src == `PIO_SRC_ECS) begin
        pick_out = ecs;
      end else begin
        pick_out = dout;
      end
    end
  endfunction

  // Repeats a written byte across a field vector of two bits per pin.
  function [2*WW-1:0] spread_codes;
    input [7:0] v;
    integer     j;
    begin
      for (j = 0; j < 2*WW; j = j + 1) begin
        spread_codes[j] = v[j % 8];
      end
    end
  endfunction

  // Driver enable is the defined enable term ORed with the direction bit.
  function oe_of;
    input def;
    input pt;
    input dir;
    begin
      oe_of = (def & pt) | dir;
    end
  endfunction

  pio_imc #(.W(WW)) u_imc_b (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_pin     (i_pin_b),
    .i_mode    (imode_b_q),
    .i_pt_lo   (i_imc_pt[0]),
    .i_pt_hi   (i_imc_pt[1]),
    .o_imc     (imc_b)
  );

  pio_imc #(.W(WW)) u_imc_c (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_pin     (i_pin_c),
    .i_mode    (imode_c_q),
    .i_pt_lo   (i_imc_pt[2]),
    .i_pt_hi   (i_imc_pt[3]),
    .o_imc     (imc_c)
  );

  // Configuration register writes from the DSP bus.
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      dout_b_q  <= `PIO_RST_DOUT;
      dout_c_q  <= `PIO_RST_DOUT;
      dout_d_q  <= {NW{1'b0}};
      dir_b_q   <= `PIO_RST_DIR;
      dir_c_q   <= `PIO_RST_DIR;
      dir_d_q   <= {NW{1'b0}};
      src_b_q   <= {(2*WW){1'b0}};
      src_c_q   <= {(2*WW){1'b0}};
      src_d_q   <= {(2*NW){1'b0}};
      imode_b_q <= {(2*WW){1'b0}};
      imode_c_q <= {(2*WW){1'b0}};
    end else if (i_bus_wr && i_hit_io) begin
      if (i_port_sel == `PIO_PORT_FIRST) begin
        if (i_reg_sel == `PIO_SEL_DATA_OUT) begin
          dout_b_q <= i_wdata[WW-1:0];
        end else if (i_reg_sel == `PIO_SEL_DIR) begin
          dir_b_q <= i_wdata[WW-1:0];
        end else if (i_reg_sel == `PIO_SEL_SRC) begin
          src_b_q <= spread_codes(i_wdata);
        end else if (i_reg_sel == `PIO_SEL_IMODE) begin
          imode_b_q <= spread_codes(i_wdata);
        end
      end else if (i_port_sel == `PIO_PORT_SECOND) begin
        if (i_reg_sel == `PIO_SEL_DATA_OUT) begin
          dout_c_q <= i_wdata[WW-1:0];
        end else if (i_reg_sel == `PIO_SEL_DIR) begin
          dir_c_q <= i_wdata[WW-1:0];
        end else if (i_reg_sel == `PIO_SEL_SRC) begin
          src_c_q <= spread_codes(i_wdata);
        end else if (i_reg_sel == `PIO_SEL_IMODE) begin
          imode_c_q <= spread_codes(i_wdata);
        end
      end else if (i_port_sel == `PIO_PORT_NARROW) begin
        if (i_reg_sel == `PIO_SEL_DATA_OUT) begin
          dout_d_q <= i_wdata[NW-1:0];
        end else if (i_reg_sel == `PIO_SEL_DIR) begin
          dir_d_q <= i_wdata[NW-1:0];
        end else if (i_reg_sel == `PIO_SEL_SRC) begin
          src_d_q <= i_wdata[2*NW-1:0];
        end
      end
    end
  end

  // Pin drivers, enables and logic-array inputs.
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pin_b      <= {WW{1'b0}};
      o_pin_c      <= {WW{1'b0}};
      o_pin_d      <= {NW{1'b0}};
      o_pin_oe_b   <= {WW{1'b0}};
      o_pin_oe_c   <= {WW{1'b0}};
      o_pin_oe_d   <= {NW{1'b0}};
      o_array_in_b <= {WW{1'b0}};
      o_array_in_c <= {WW{1'b0}};
      o_array_in_d <= {NW{1'b0}};
      o_isp_in     <= 4'h0;
    end else begin
      for (n = 0; n < WW; n = n + 1) begin
        o_pin_b[n]    <= pick_out(src_b_q[2*n +: 2] & 2'h1, dout_b_q[n],
                                  i_omc_first[n], 1'b0);
        o_pin_oe_b[n] <= oe_of(i_oe_def_b[n], i_oe_pt_b[n], dir_b_q[n]);
        if (i_isp_en && n < 4) begin
          o_pin_c[n]    <= i_isp_out[n % 4];
          o_pin_oe_c[n] <= i_isp_oe[n % 4];
        end else begin
          o_pin_c[n]    <= pick_out(src_c_q[2*n +: 2] & 2'h1, dout_c_q[n],
                                    i_omc_shared[n], 1'b0);
          o_pin_oe_c[n] <= oe_of(i_oe_def_c[n], i_oe_pt_c[n], dir_c_q[n]);
        end
      end
      for (n = 0; n < NW; n = n + 1) begin
        o_pin_d[n]    <= pick_out(src_d_q[2*n +: 2], dout_d_q[n], 1'b0,
                                  i_ecs[n]);
        o_pin_oe_d[n] <= oe_of(i_oe_def_d[n], i_oe_pt_d[n], dir_d_q[n]);
      end
      o_array_in_b <= imc_b;
      o_array_in_c <= imc_c;
      o_array_in_d <= i_pin_d;
      o_isp_in     <= i_isp_en ? i_pin_c[3:0] : 4'h0;
    end
  end

  // Readback buffer: one source per access onto the read bus.
  always @* begin
    rd_mux = 8'h00;
    if (i_hit_omc) begin
      if (i_port_sel == `PIO_PORT_FIRST) begin
        rd_mux = i_omc_first;
      end else if (i_port_sel == `PIO_PORT_SECOND) begin
        rd_mux = i_omc_shared;
      end
    end else if (i_hit_imc) begin
      if (i_port_sel == `PIO_PORT_FIRST) begin
        rd_mux = imc_b;
      end else if (i_port_sel == `PIO_PORT_SECOND) begin
        rd_mux = imc_c;
      end
    end else if (i_hit_io) begin
      if (i_port_sel == `PIO_PORT_FIRST) begin
        if (i_reg_sel == `PIO_SEL_DATA_IN) begin
          rd_mux = i_pin_b;
        end else if (i_reg_sel == `PIO_SEL_DATA_OUT) begin
          rd_mux = dout_b_q;
        end else if (i_reg_sel == `PIO_SEL_DIR) begin
          rd_mux = dir_b_q;
        end else if (i_reg_sel == `PIO_SEL_OMC) begin
          rd_mux = i_omc_first;
        end else if (i_reg_sel == `PIO_SEL_IMC) begin
          rd_mux = imc_b;
        end else if (i_reg_sel == `PIO_SEL_SRC) begin
          rd_mux = src_b_q[7:0];
        end else if (i_reg_sel == `PIO_SEL_IMODE) begin
          rd_mux = imode_b_q[7:0];
        end
      end else if (i_port_sel == `PIO_PORT_SECOND) begin
        if (i_reg_sel == `PIO_SEL_DATA_IN) begin
          rd_mux = i_pin_c;
        end else if (i_reg_sel == `PIO_SEL_DATA_OUT) begin
          rd_mux = dout_c_q;
        end else if (i_reg_sel == `PIO_SEL_DIR) begin
          rd_mux = dir_c_q;
        end else if (i_reg_sel == `PIO_SEL_OMC) begin
          rd_mux = i_omc_shared;
        end else if (i_reg_sel == `PIO_SEL_IMC) begin
          rd_mux = imc_c;
        end else if (i_reg_sel == `PIO_SEL_SRC) begin
          rd_mux = src_c_q[7:0];
        end else if (i_reg_sel == `PIO_SEL_IMODE) begin
          rd_mux = imode_c_q[7:0];
        end
      end else if (i_port_sel == `PIO_PORT_NARROW) begin
        if (i_reg_sel == `PIO_SEL_DATA_IN) begin
          rd_mux = pad_narrow(i_pin_d);
        end else if (i_reg_sel == `PIO_SEL_DATA_OUT) begin
          rd_mux = pad_narrow(dout_d_q);
        end else if (i_reg_sel == `PIO_SEL_DIR) begin
          rd_mux = pad_narrow(dir_d_q);
        end else if (i_reg_sel == `PIO_SEL_SRC) begin
          rd_mux = {2'h0, src_d_q};
        end
      end
    end
  end

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata  <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rdata  <= i_bus_rd ? rd_mux : 8'h00;
      o_rvalid <= i_bus_rd & (i_hit_io | i_hit_omc | i_hit_imc);
    end
  end
endmodule // pio_port_block

// File: src/pio_defs.vh
`ifndef PIO_DEFS_VH
`define PIO_DEFS_VH
// Port widths.
`define PIO_WIDE_W        8
`define PIO_NARROW_W      3
// Register selects within the I/O control block (per port).
`define PIO_SEL_W         3
`define PIO_SEL_DATA_IN   3'h0
`define PIO_SEL_DATA_OUT  3'h1
`define PIO_SEL_DIR       3'h2
`define PIO_SEL_OMC       3'h3
`define PIO_SEL_IMC       3'h4
`define PIO_SEL_SRC       3'h5
`define PIO_SEL_IMODE     3'h6
// Port selects.
`define PIO_PORT_FIRST    2'h0
`define PIO_PORT_SECOND   2'h1
`define PIO_PORT_NARROW   2'h2
// Output source codes per pin.
`define PIO_SRC_DOUT      2'h0
`define PIO_SRC_OMC       2'h1
`define PIO_SRC_ECS       2'h2
// Input macrocell modes per pin.
`define PIO_IMC_PASS      2'h0
`define PIO_IMC_REG       2'h1
`define PIO_IMC_LATCH     2'h2
// Reset values.
`define PIO_RST_DIR       8'h00
`define PIO_RST_DOUT      8'h00
`endif

// File: src/pio_imc.v
`timescale 1ns/100ps
`include "pio_defs.vh"
// Input macrocells of one eight-pin port: register, latch or pass-through per pin.
module pio_imc #(
  parameter W = 8
) (
  input  wire             i_clk_sys,
  input  wire             i_rstn,
  input  wire [W-1:0]     i_pin,
  input  wire [2*W-1:0]   i_mode,
  input  wire             i_pt_lo,
  input  wire             i_pt_hi,
  output reg  [W-1:0]     o_imc
);
  reg [W-1:0] cap_q;
  reg [W-1:0] pt_last_q;
  reg [W-1:0] pt_now;
  integer     k;
  integer     j;
  integer     m;
  always @* begin
    for (k = 0; k < W; k = k + 1) begin
      pt_now[k] = (k < W/2) ? i_pt_lo : i_pt_hi;
    end
  end
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cap_q     <= {W{1'b0}};
      pt_last_q <= {W{1'b0}};
    end else begin
      pt_last_q <= pt_now;
      for (j = 0; j < W; j = j + 1) begin
        if (i_mode[2*j +: 2] == `PIO_IMC_REG && pt_now[j] && !pt_last_q[j]) begin
          cap_q[j] <= i_pin[j];
        end else if (i_mode[2*j +: 2] == `PIO_IMC_LATCH && pt_now[j]) begin
          cap_q[j] <= i_pin[j];
        end
      end
    end
  end
  always @* begin
    for (m = 0; m < W; m = m + 1) begin
      if (i_mode[2*m +: 2] == `PIO_IMC_PASS) begin
        o_imc[m] = i_pin[m];
      end else if (i_mode[2*m +: 2] == `PIO_IMC_LATCH && pt_now[m]) begin
        o_imc[m] = i_pin[m];
      end else begin
        o_imc[m] = cap_q[m];
      end
    end
  end
endmodule // pio_imc

// File: tb/pio_port_block_assertions.sv
`timescale 1ns/100ps
module pio_port_block_chk #(
  parameter WW = 8,
  parameter NW = 3
) (
  input wire          i_clk_sys,
  input wire          i_rstn,
  input wire          i_bus_rd,
  input wire          i_hit_io,
  input wire [1:0]    i_port_sel,
  input wire [2:0]    i_reg_sel,
  input wire [WW-1:0] i_oe_pt_b,
  input wire [WW-1:0] i_oe_def_b,
  input wire          i_isp_en,
  input wire [WW-1:0] i_pin_b,
  input wire [WW-1:0] i_pin_c,
  input wire [NW-1:0] i_pin_d,
  input wire [WW-1:0] o_pin_oe_b,
  input wire [WW-1:0] o_pin_oe_c,
  input wire [NW-1:0] o_pin_oe_d,
  input wire [NW-1:0] o_array_in_d,
  input wire [3:0]    o_isp_in,
  input wire [7:0]    o_rdata,
  input wire          o_rvalid
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);
  wire [WW-1:0] pt_b = i_oe_def_b & i_oe_pt_b;
  wire [3:0]    pc_lo = i_pin_c[3:0];
  chk_rd_answer: assert property (i_bus_rd && i_hit_io |=> o_rvalid)
    else $error("read not answered");
  chk_rd_single: assert property (!i_bus_rd |=> !o_rvalid)
    else $error("answer without read");
  chk_narrow_zero: assert property (i_bus_rd && i_hit_io && i_port_sel == 2'h2
    && i_reg_sel < 3'h3 |=> o_rdata[7:3] == 5'h00) else $error("narrow upper bits set");
  chk_datain_pin: assert property (i_bus_rd && i_hit_io && i_port_sel == 2'h0
    && i_reg_sel == 3'h0 |=> o_rdata == $past(i_pin_b)) else $error("data-in not pin");
  chk_oe_term: assert property ((o_pin_oe_b & $past(pt_b)) == $past(pt_b))
    else $error("enable term ignored");
  chk_narrow_direct: assert property (o_array_in_d == $past(i_pin_d))
    else $error("narrow array input wrong");
  chk_isp_route: assert property (o_isp_in == ($past(i_isp_en) ? $past(pc_lo) : 4'h0))
    else $error("programming input wrong");
  chk_reset_input: assert property ($rose(i_rstn) |-> o_pin_oe_b == 8'h00
    && o_pin_oe_c == 8'h00 && o_pin_oe_d == 3'h0) else $error("pin driven after reset");
  cover property (i_bus_rd && i_hit_io && i_port_sel == 2'h2);
  cover property (|pt_b);
  cover property (i_isp_en);
endmodule // pio_port_block_chk
bind pio_port_block pio_port_block_chk #(.WW(WW), .NW(NW)) pio_port_block_chk_i (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_bus_rd(i_bus_rd), .i_hit_io(i_hit_io),
  .i_port_sel(i_port_sel), .i_reg_sel(i_reg_sel), .i_oe_pt_b(i_oe_pt_b),
  .i_oe_def_b(i_oe_def_b), .i_isp_en(i_isp_en), .i_pin_b(i_pin_b), .i_pin_c(i_pin_c),
  .i_pin_d(i_pin_d), .o_pin_oe_b(o_pin_oe_b), .o_pin_oe_c(o_pin_oe_c),
  .o_pin_oe_d(o_pin_oe_d), .o_array_in_d(o_array_in_d), .o_isp_in(o_isp_in),
  .o_rdata(o_rdata), .o_rvalid(o_rvalid));

// File: tb/pio_dsp_model.sv
`timescale 1ns/100ps
module pio_dsp_model (
  input  wire       i_clk_sys,
  input  wire [7:0] i_rdata,
  input  wire       i_rvalid,
  output reg        o_bus_wr,
  output reg        o_bus_rd,
  output reg        o_hit_io,
  output reg  [1:0] o_port_sel,
  output reg  [2:0] o_reg_sel,
  output reg  [7:0] o_wdata
);
  integer i;
  initial begin
    {o_bus_wr, o_bus_rd, o_hit_io, o_port_sel, o_reg_sel, o_wdata} = 16'h0000;
  end
  // The released data bus shows the inverse of the last value.
  task wr(input [1:0] p, input [2:0] r, input [7:0] v);
    @(negedge i_clk_sys);
    {o_bus_wr, o_hit_io, o_port_sel, o_reg_sel, o_wdata} = {2'h3, p, r, v};
    @(negedge i_clk_sys);
    {o_bus_wr, o_hit_io, o_wdata} = {2'h0, ~v};
  endtask
  task rd(input [1:0] p, input [2:0] r, output [7:0] v);
    v = 8'hXX;
    @(negedge i_clk_sys);
    {o_bus_rd, o_hit_io, o_port_sel, o_reg_sel} = {2'h3, p, r};
    @(negedge i_clk_sys);
    {o_bus_rd, o_hit_io} = 2'h0;
    for (i = 0; i < 3; i = i + 1) begin
      if (i_rvalid === 1'b1) begin
        v = i_rdata;
        i = 3;
      end else @(negedge i_clk_sys);
    end
  endtask
endmodule // pio_dsp_model

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  reg        i_clk_sys, i_rstn, isp_en;
  reg  [7:0] omc_f, omc_s, pt_b, pt_c, def_b, def_c, ext_b, ext_c, d;
  reg  [2:0] ecs, pt_d, def_d, ext_d;
  reg  [3:0] imc_pt, isp_out, isp_oe;
  wire       wr, rd, hit, rvalid;
  wire [1:0] psel;
  wire [2:0] rsel, pd, oed, aid, pin_d;
  wire [7:0] wdata, rdata, pb, pc, oeb, oec, aib, aic, pin_b, pin_c;
  wire [3:0] isp_in;
  integer    n_fail, compares;
  // Pin level is the device drive where enabled, else the outside source.
  assign pin_b = (oeb & pb) | (~oeb & ext_b);
  assign pin_c = (oec & pc) | (~oec & ext_c);
  assign pin_d = (oed & pd) | (~oed & ext_d);
  pio_dsp_model pio_dsp_model_i (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_bus_wr(wr), .o_bus_rd(rd), .o_hit_io(hit), .o_port_sel(psel), .o_reg_sel(rsel),
    .o_wdata(wdata));
  pio_port_block pio_port_block_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_bus_wr(wr),
    .i_bus_rd(rd), .i_hit_io(hit), .i_hit_omc(1'b0), .i_hit_imc(1'b0), .i_port_sel(psel),
    .i_reg_sel(rsel), .i_wdata(wdata), .i_omc_first(omc_f), .i_omc_shared(omc_s),
    .i_ecs(ecs), .i_oe_pt_b(pt_b), .i_oe_pt_c(pt_c), .i_oe_pt_d(pt_d), .i_oe_def_b(def_b),
    .i_oe_def_c(def_c), .i_oe_def_d(def_d), .i_imc_pt(imc_pt), .i_isp_en(isp_en),
    .i_isp_out(isp_out), .i_isp_oe(isp_oe), .i_pin_b(pin_b), .i_pin_c(pin_c),
    .i_pin_d(pin_d), .o_pin_b(pb), .o_pin_c(pc), .o_pin_d(pd), .o_pin_oe_b(oeb),
    .o_pin_oe_c(oec), .o_pin_oe_d(oed), .o_array_in_b(aib), .o_array_in_c(aic),
    .o_array_in_d(aid), .o_isp_in(isp_in), .o_rdata(rdata), .o_rvalid(rvalid));
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  task chk(input [7:0] g, input [7:0] e);
    compares = compares + 1;
    if (g !== e) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      n_fail = n_fail + 1;
    end
  endtask
  task w(input [1:0] p, input [2:0] r, input [7:0] v);
    pio_dsp_model_i.wr(p, r, v);
  endtask
  task rc(input [1:0] p, input [2:0] r, input [7:0] e);
    pio_dsp_model_i.rd(p, r, d);
    chk(d, e);
  endtask
  task s4;
    repeat (4) @(negedge i_clk_sys);
  endtask
  task final_report;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task t_reset;
    chk(oeb, 8'h00);
    chk({oec[4:0], oed}, 8'h00);
    rc(2'h0, 3'h2, 8'h00);
    $display("test reset done");
  endtask
  task t_cpu_io;
    ext_b = 8'h5A;
    w(2'h0, 3'h2, 8'hFF);
    w(2'h0, 3'h1, 8'hA5);
    s4;
    chk(pb, 8'hA5);
    chk(oeb, 8'hFF);
    rc(2'h0, 3'h0, 8'hA5);
    rc(2'h0, 3'h1, 8'hA5);
    w(2'h0, 3'h2, 8'h0F);
    rc(2'h0, 3'h2, 8'h0F);
    rc(2'h0, 3'h0, 8'h55);
    $display("test cpu_io done");
  endtask
  task t_oe;
    w(2'h0, 3'h2, 8'h00);
    pt_b = 8'hFF;
    s4;
    chk(oeb, 8'h00);
    def_b = 8'h0F;
    s4;
    chk(oeb, 8'h0F);
    w(2'h0, 3'h2, 8'h30);
    s4;
    chk(oeb, 8'h3F);
    pt_b = 8'h00;
    w(2'h0, 3'h2, 8'h00);
    s4;
    chk(oeb, 8'h00);
    $display("test oe done");
  endtask
  task t_src;
    omc_s = 8'h3C;
    omc_f = 8'hC3;
    ecs = 3'h5;
    w(2'h1, 3'h2, 8'hFF);
    w(2'h1, 3'h5, 8'hFF);
    w(2'h1, 3'h1, 8'h00);
    w(2'h0, 3'h2, 8'hFF);
    w(2'h0, 3'h5, 8'hFF);
    w(2'h2, 3'h2, 8'hFF);
    w(2'h2, 3'h5, 8'h2A);
    w(2'h2, 3'h1, 8'hFF);
    s4;
    chk(pc, 8'h3C);
    chk(pb, 8'hC3);
    chk(pd, 3'h5);
    chk(oec, 8'hFF);
    chk(oed, 3'h7);
    rc(2'h2, 3'h2, 8'h07);
    rc(2'h2, 3'h7, 8'h00);
    rc(2'h2, 3'h1, 8'h07);
    $display("test src done");
  endtask
  task t_imc;
    w(2'h0, 3'h2, 8'h00);
    w(2'h0, 3'h6, 8'h55);
    ext_b = 8'h11;
    s4;
    imc_pt = 4'h3;
    s4;
    chk(aib, 8'h11);
    ext_b = 8'hEE;
    s4;
    chk(aib, 8'h11);
    rc(2'h0, 3'h4, 8'h11);
    w(2'h0, 3'h6, 8'hAA);
    s4;
    chk(aib, 8'hEE);
    imc_pt = 4'h0;
    s4;
    ext_b = 8'h77;
    s4;
    chk(aib, 8'hEE);
    w(2'h0, 3'h6, 8'h00);
    ext_d = 3'h6;
    w(2'h2, 3'h2, 8'h00);
    s4;
    chk(aib, 8'h77);
    chk(aid, 3'h6);
    $display("test imc done");
  endtask
  task t_isp;
    w(2'h1, 3'h2, 8'h00);
    ext_c = 8'h96;
    isp_out = 4'h3;
    isp_en = 1'b1;
    s4;
    chk(isp_in, 4'h6);
    chk({oec[3:0], pc[3:0]}, 8'h03);
    chk(pc, 8'h33);
    chk(aic, 8'h96);
    isp_en = 1'b0;
    s4;
    chk(isp_in, 4'h0);
    chk(pc, 8'h3C);
    $display("test isp done");
  endtask
  initial begin
    {omc_f, omc_s, pt_b, pt_c, def_b, def_c, ext_b, ext_c} = 64'h0;
    {ecs, pt_d, def_d, ext_d, imc_pt, isp_out, isp_oe, isp_en} = 25'h0;
    n_fail = 0;
    compares = 0;
    i_rstn = 1'b0;
    repeat (20) @(negedge i_clk_sys);
    i_rstn = 1'b1;
    t_reset;
    t_cpu_io;
    t_oe;
    t_src;
    t_imc;
    t_isp;
    final_report;
  end
  initial begin
    #20000;
    n_fail = n_fail + 1;
    final_report;
  end
endmodule // tb_top
